//--- include/ssf_defs.svh
// offsets, field positions and reset values of the sticky status block
// assumes inclusion by bare name from the package and the design files
`ifndef SSF_DEFS_SVH
`define SSF_DEFS_SVH

// byte offsets on the register bus
`define SSF_OFF_X_STICKY 12'h000
`define SSF_OFF_Y_STICKY 12'h004
`define SSF_OFF_MODE 12'h008
`define SSF_OFF_DATA 12'h100

// reset values and masks
`define SSF_STICKY_RESET 32'h0000_0000
`define SSF_WR_MASK 32'h001e_03e7
`define SSF_LIVE_MASK 32'h0560_0000

// field positions in a sticky register
`define SSF_BIT_ALU_UNDERFLOW 0
`define SSF_BIT_ALU_OVF_B 1
`define SSF_BIT_ALU_OVF_A 2
`define SSF_BIT_ALU_INVALID 5
`define SSF_BIT_MULT_FIX_OVF 6
`define SSF_BIT_MULT_OVF 7
`define SSF_BIT_MULT_UNDERFLOW 8
`define SSF_BIT_MULT_INVALID 9
`define SSF_BIT_CB7 17
`define SSF_BIT_CB15 18
`define SSF_BIT_ILL_IO 19
`define SSF_BIT_UNALIGNED 20
`define SSF_BIT_PC_FULL 21
`define SSF_BIT_PC_EMPTY 22
`define SSF_BIT_SS_OVF 23
`define SSF_BIT_SS_EMPTY 24
`define SSF_BIT_LOOP_OVF 25
`define SSF_BIT_LOOP_EMPTY 26

// field of the mode register
`define SSF_BIT_DET_EN 0

// pc stack pointer figures
`define SSF_PC_PTR_EMPTY 5'h00
`define SSF_PC_PTR_FULL 5'h1f

// data register file shape
`define SSF_DATA_DEPTH 16
`define SSF_DATA_WIDTH 40

`endif

//--- include/ssf_pkg.sv
// types shared by the sticky status block
// assumes ssf_defs.svh on the include path
`include "ssf_defs.svh"

package ssf_pkg;

  // live flags of one processing element
  typedef struct packed {
    logic aluInvalidLive;
    logic aluOverflowLive;
    logic aluZeroLive;
    logic multInvalidLive;
    logic multUnderflowLive;
    logic multOverflowLive;
    logic unalignedLongAccess;
    logic illegalIoRegAccess;
    logic circbuf15Latch;
    logic circbuf7Latch;
  } ssf_arith_t;

  // bus handshake sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_ANSWER = 3'b100
  } ssf_apb_state_t;

  // whole state of the top module
  typedef struct packed {
    ssf_apb_state_t apbState;
    logic [1:0][31:0] sticky;
    logic detectEn;
    logic [31:0] prdata;
    logic slverr;
  } ssf_top_state_t;

  localparam ssf_top_state_t SSF_TOP_RESET = '{
    apbState: ST_IDLE,
    sticky: {`SSF_STICKY_RESET, `SSF_STICKY_RESET},
    detectEn: 1'b0,
    prdata: 32'h0000_0000,
    slverr: 1'b0
  };

endpackage

//--- include/ssf_mem_if.sv
// port bundle between the bus logic and the data register memory
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none

interface ssf_mem_if #(
  parameter int AW = 4,
  parameter int DW = 40
);
  logic [AW-1:0] addr;
  logic wrLo;
  logic wrHi;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;

  modport ctrl(output addr, output wrLo, output wrHi, output wdata, input rdata);
  modport mem(input addr, input wrLo, input wrHi, input wdata, output rdata);
endinterface

`default_nettype wire

//--- hw/ssf_data_mem.sv
// data register file of element x, low word and high bits written apart
// assumes addresses in range; read data registered every cycle
`timescale 1ns/1ps
`default_nettype none
`include "ssf_defs.svh"

module ssf_data_mem #(
  parameter int DEPTH = `SSF_DATA_DEPTH,
  parameter int WIDTH = `SSF_DATA_WIDTH
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  ssf_mem_if.mem bus
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rdata;
  } ssf_mem_state_t;

  ssf_mem_state_t st_q;
  ssf_mem_state_t st_d;

  // stored bits never depend on fixed or float reading
  always_comb begin
    st_d = st_q;
    if (bus.wrLo) begin
      st_d.mem[bus.addr][31:0] = bus.wdata[31:0];
    end
    if (bus.wrHi) begin
      st_d.mem[bus.addr][WIDTH-1:32] = bus.wdata[WIDTH-1:32];
    end
    st_d.rdata = st_q.mem[bus.addr];
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus.rdata = st_q.rdata;

endmodule

`default_nettype wire

//--- hw/ssf_sticky_flags.sv
// sticky status registers of both processing elements and the x data
// registers, reached over an apb slave
// assumes all flag inputs come from logic on sys_clk
//
// Notes on behaviour
// - sticky bits stay set until software clears them; bits 25 and 23 until reset.
// - bit 5 latches the live alu invalid flag.
// - bit 26 reads loop stacks empty, live, read-only.
// - bit 25 is read-only sticky loop stack overflow.
// - bit 24 reads status stack empty, live, read-only.
// - bit 23 is read-only sticky status stack overflow.
// - bit 22 reads pc stack empty, live, read-only.
// - bit 21 reads pc stack full, live, read-only.
// - bit 20 latches an unaligned forced long word access.
// - bit 19 latches illegal io accesses while detection is enabled.
// - bit 18 latches the circular buffer 15 interrupt latch.
// - bit 17 latches the circular buffer 7 interrupt latch.
// - bit 9 latches the live multiplier invalid flag.
// - bit 8 latches the live multiplier underflow flag.
// - bits 7 and 6 both latch the live multiplier overflow.
// - bits 2 and 1 both latch the live alu overflow.
// - bit 0 latches the live alu zero flag.
// - x register is fed by element x flags and by the shared stack overflow inputs.
// - y register has the same layout, fed by element y.
// - x data registers are 40 bits, read and write.
// - pc pointer 0 means empty, 31 means full.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ssf_defs.svh"

module ssf_sticky_flags #(
  parameter int DATA_DEPTH = `SSF_DATA_DEPTH,
  parameter int DATA_WIDTH = `SSF_DATA_WIDTH
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire ssf_pkg::ssf_arith_t xLiveArithFlags,
  input wire ssf_pkg::ssf_arith_t yLiveArithFlags,
  input wire logic loopStackEmpty,
  input wire logic loopStackOverflow,
  input wire logic statusStackEmpty,
  input wire logic statusStackOverflow,
  input wire logic [4:0] pcStackPointer,
  output logic illegalAccessDetectEn
);

  localparam int AW = $clog2(DATA_DEPTH);

  // ***************************************************
  // parameter checks
  // ***************************************************

  // high part must fit in one bus word, index must fit the window
  if (DATA_WIDTH < 33 || DATA_WIDTH > 64) begin : g_bad_width
    $error("data width must be 33 to 64");
  end
  if (DATA_DEPTH < 2 || DATA_DEPTH > 64 || (1 << AW) != DATA_DEPTH) begin : g_bad_depth
    $error("data depth must be a power of two from 2 to 64");
  end

  // ***************************************************
  // state and decode
  // ***************************************************

  ssf_pkg::ssf_top_state_t st_q;
  ssf_pkg::ssf_top_state_t st_d;

  ssf_pkg::ssf_arith_t arith [2];
  logic [31:0] setVec [2];
  logic [31:0] rdVal [2];
  logic [31:0] liveBits;
  logic pcEmpty;
  logic pcFull;
  logic [11:0] dataOff;
  logic dataHit;
  logic hitX;
  logic hitY;
  logic hitMode;
  logic anyHit;
  logic busWrite;

  ssf_mem_if #(.AW(AW), .DW(DATA_WIDTH)) memBus ();

  ssf_data_mem #(
    .DEPTH(DATA_DEPTH),
    .WIDTH(DATA_WIDTH)
  ) u_data_mem (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .bus(memBus)
  );

  // pc stack state follows the pointer value
  assign pcEmpty = (pcStackPointer == `SSF_PC_PTR_EMPTY);
  assign pcFull = (pcStackPointer == `SSF_PC_PTR_FULL);

  // live bits are never stored, so they can not go stale
  assign liveBits =
      (32'(loopStackEmpty) << `SSF_BIT_LOOP_EMPTY)
    | (32'(statusStackEmpty) << `SSF_BIT_SS_EMPTY)
    | (32'(pcEmpty) << `SSF_BIT_PC_EMPTY)
    | (32'(pcFull) << `SSF_BIT_PC_FULL);

  // address decode; data words sit in pairs, low word first
  assign dataOff = paddr - `SSF_OFF_DATA;
  assign dataHit = (paddr >= `SSF_OFF_DATA) && (dataOff[11:3] < 9'(DATA_DEPTH));
  assign hitX = (paddr == `SSF_OFF_X_STICKY);
  assign hitY = (paddr == `SSF_OFF_Y_STICKY);
  assign hitMode = (paddr == `SSF_OFF_MODE);
  assign anyHit = hitX | hitY | hitMode | dataHit;

  // a write takes effect only at the edge that completes the transfer
  assign busWrite = pready & pwrite;

  // ***************************************************
  // per element flag sources
  // ***************************************************

  // each register sees only its own element
  assign arith[0] = xLiveArithFlags;
  // the y element has the identical map
  assign arith[1] = yLiveArithFlags;

  for (genvar g = 0; g < 2; g++) begin : g_elem
    // set terms; overflow bits share a source by design
    assign setVec[g] =
        (32'(arith[g].aluZeroLive) << `SSF_BIT_ALU_UNDERFLOW)
      | (32'(arith[g].aluOverflowLive) << `SSF_BIT_ALU_OVF_B)
      | (32'(arith[g].aluOverflowLive) << `SSF_BIT_ALU_OVF_A)
      | (32'(arith[g].aluInvalidLive) << `SSF_BIT_ALU_INVALID)
      | (32'(arith[g].multOverflowLive) << `SSF_BIT_MULT_FIX_OVF)
      | (32'(arith[g].multOverflowLive) << `SSF_BIT_MULT_OVF)
      | (32'(arith[g].multUnderflowLive) << `SSF_BIT_MULT_UNDERFLOW)
      | (32'(arith[g].multInvalidLive) << `SSF_BIT_MULT_INVALID)
      | (32'(arith[g].circbuf7Latch) << `SSF_BIT_CB7)
      | (32'(arith[g].circbuf15Latch) << `SSF_BIT_CB15)
      | (32'(arith[g].illegalIoRegAccess & st_q.detectEn) << `SSF_BIT_ILL_IO)
      | (32'(arith[g].unalignedLongAccess) << `SSF_BIT_UNALIGNED)
      | (32'(statusStackOverflow) << `SSF_BIT_SS_OVF)
      | (32'(loopStackOverflow) << `SSF_BIT_LOOP_OVF);

    // read view: stored bits outside live places, unlisted bits zero
    assign rdVal[g] = (st_q.sticky[g] & ~`SSF_LIVE_MASK) | liveBits;
  end

  // ***************************************************
  // memory port
  // ***************************************************

  // address follows paddr so the read is ready one cycle after setup
  always_comb begin
    memBus.addr = dataOff[AW+2:3];
    memBus.wdata = {pwdata[DATA_WIDTH-33:0], pwdata};
    memBus.wrLo = busWrite & dataHit & ~paddr[2];
    memBus.wrHi = busWrite & dataHit & paddr[2];
  end

  // ***************************************************
  // next state
  // ***************************************************

  // set wins over a clearing write in the same cycle
  always_comb begin
    st_d = st_q;
    for (int g = 0; g < 2; g++) begin
      if (busWrite && ((g == 0) ? hitX : hitY)) begin
        // stack overflow bits keep their value
        st_d.sticky[g] = (pwdata & `SSF_WR_MASK)
                       | (st_q.sticky[g] & ~`SSF_WR_MASK);
      end
      st_d.sticky[g] = st_d.sticky[g] | setVec[g];
    end
    if (busWrite && hitMode) begin
      st_d.detectEn = pwdata[`SSF_BIT_DET_EN];
    end
    case (st_q.apbState)
      ssf_pkg::ST_IDLE: begin
        if (psel && !penable) begin
          st_d.apbState = ssf_pkg::ST_FETCH;
        end
      end
      ssf_pkg::ST_FETCH: begin
        // capture the answer; memory data arrived this cycle
        st_d.slverr = ~anyHit;
        if (hitX) begin
          st_d.prdata = rdVal[0];
        end else if (hitY) begin
          st_d.prdata = rdVal[1];
        end else if (hitMode) begin
          st_d.prdata = 32'(st_q.detectEn) << `SSF_BIT_DET_EN;
        end else if (dataHit && paddr[2]) begin
          st_d.prdata = 32'(memBus.rdata[DATA_WIDTH-1:32]);
        end else if (dataHit) begin
          st_d.prdata = memBus.rdata[31:0];
        end else begin
          st_d.prdata = 32'h0000_0000;
        end
        st_d.apbState = psel ? ssf_pkg::ST_ANSWER : ssf_pkg::ST_IDLE;
      end
      ssf_pkg::ST_ANSWER: begin
        st_d.apbState = ssf_pkg::ST_IDLE;
      end
      default: begin
        st_d.apbState = ssf_pkg::ST_IDLE;
      end
    endcase
  end

  // single register stage for all state
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_q <= ssf_pkg::SSF_TOP_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************

  // one wait state on every transfer, no fast path
  assign pready = psel & penable & (st_q.apbState == ssf_pkg::ST_ANSWER);
  assign prdata = st_q.prdata;
  assign pslverr = pready & st_q.slverr;
  assign illegalAccessDetectEn = st_q.detectEn;

  // ***************************************************
  // checks
  // ***************************************************

  // a set x bit with no write to the x register stays set
  property p_sticky_hold;
    @(posedge sys_clk) disable iff (!reset_n)
    (st_q.sticky[0][`SSF_BIT_MULT_INVALID] && !(busWrite && hitX))
      |=> st_q.sticky[0][`SSF_BIT_MULT_INVALID];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("sticky bit lost without a write");

  // alu invalid sets bit 5 and it outlives the live flag
  property p_alu_invalid;
    @(posedge sys_clk) disable iff (!reset_n)
    (xLiveArithFlags.aluInvalidLive ##1 !(busWrite && hitX) [*2])
      |-> st_q.sticky[0][`SSF_BIT_ALU_INVALID];
  endproperty
  a_alu_invalid: assert property (p_alu_invalid)
    else $error("alu invalid sticky not held");

  // x readback shows loop empty live
  property p_loop_empty;
    @(posedge sys_clk) disable iff (!reset_n)
    rdVal[0][`SSF_BIT_LOOP_EMPTY] == loopStackEmpty;
  endproperty
  a_loop_empty: assert property (p_loop_empty)
    else $error("loop empty bit not live");

  // loop overflow survives a write of zeros
  property p_loop_ovf;
    @(posedge sys_clk) disable iff (!reset_n)
    loopStackOverflow |=> st_q.sticky[1][`SSF_BIT_LOOP_OVF] [*3];
  endproperty
  a_loop_ovf: assert property (p_loop_ovf)
    else $error("loop overflow sticky lost");

  // pc empty and full follow the pointer on the y register
  property p_pc_state;
    @(posedge sys_clk) disable iff (!reset_n)
    rdVal[1][`SSF_BIT_PC_EMPTY] == (pcStackPointer == `SSF_PC_PTR_EMPTY)
      && rdVal[1][`SSF_BIT_PC_FULL] == (pcStackPointer == `SSF_PC_PTR_FULL);
  endproperty
  a_pc_state: assert property (p_pc_state)
    else $error("pc stack bits wrong");

  // illegal access ignored while detection is off; software may still write it
  property p_ill_gate;
    @(posedge sys_clk) disable iff (!reset_n)
    (!st_q.detectEn && !st_q.sticky[0][`SSF_BIT_ILL_IO] && !(busWrite && hitX))
      |=> !st_q.sticky[0][`SSF_BIT_ILL_IO];
  endproperty
  a_ill_gate: assert property (p_ill_gate)
    else $error("illegal access set while detection off");

  // y flags never reach the x register
  property p_x_isolated;
    @(posedge sys_clk) disable iff (!reset_n)
    (!xLiveArithFlags.multUnderflowLive && !(busWrite && hitX)
      && !st_q.sticky[0][`SSF_BIT_MULT_UNDERFLOW])
      |=> !st_q.sticky[0][`SSF_BIT_MULT_UNDERFLOW];
  endproperty
  a_x_isolated: assert property (p_x_isolated)
    else $error("x register set by a foreign source");

  // a write of zeros clears writable bits but not stack overflow
  property p_write_clear;
    @(posedge sys_clk) disable iff (!reset_n)
    (busWrite && hitY && pwdata == 32'h0000_0000
      && !yLiveArithFlags.aluOverflowLive)
      |=> !st_q.sticky[1][`SSF_BIT_ALU_OVF_A]
        && st_q.sticky[1][`SSF_BIT_SS_OVF] == ($past(st_q.sticky[1][`SSF_BIT_SS_OVF])
             | $past(statusStackOverflow));
  endproperty
  a_write_clear: assert property (p_write_clear)
    else $error("sticky write behaviour wrong");

  // every setup is answered exactly two cycles later
  property p_answer_time;
    @(posedge sys_clk) disable iff (!reset_n)
    (psel && !penable && st_q.apbState == ssf_pkg::ST_IDLE) ##1 (psel && penable)
      |-> !pready ##1 pready;
  endproperty
  a_answer_time: assert property (p_answer_time)
    else $error("bus answer timing wrong");

endmodule

`default_nettype wire

//--- verif/ssf_sticky_flags_test.sv
// self-checking bench for the sticky status block, driven over apb
// assumes the package and design files are compiled before this file
`timescale 1ns/1ps
`default_nettype none
`include "ssf_defs.svh"

module ssf_sticky_flags_test;
  // ************************************************
  // signals, clock and instance
  // ************************************************
  logic sysClk = 1'b0;
  logic resetN = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  ssf_pkg::ssf_arith_t xFlags = '0;
  ssf_pkg::ssf_arith_t yFlags = '0;
  logic loopEmpty = 1'b1;
  logic loopOvf = 1'b0;
  logic ssEmpty = 1'b1;
  logic ssOvf = 1'b0;
  logic [4:0] pcPtr = 5'h00;
  logic detectEn;
  logic expLoopOvf = 1'b0;
  logic expSsOvf = 1'b0;
  int errors = 0;
  int checksDone = 0;
  int cycles = 0;

  // 50 ns period
  always #25 sysClk = ~sysClk;

  ssf_sticky_flags dut_u (
    .sys_clk(sysClk), .reset_n(resetN), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .xLiveArithFlags(xFlags),
    .yLiveArithFlags(yFlags), .loopStackEmpty(loopEmpty), .loopStackOverflow(loopOvf),
    .statusStackEmpty(ssEmpty), .statusStackOverflow(ssOvf), .pcStackPointer(pcPtr),
    .illegalAccessDetectEn(detectEn)
  );

  // ************************************************
  // helpers
  // ************************************************
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // a hang shows as a mismatch; the whole run needs about 500 cycles
  always @(posedge sysClk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; waits for pready however long, only the timeout ends a hang
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge sysClk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge sysClk);
    penable <= 1'b1;
    do begin
      @(posedge sysClk);
      n++;
    end while (pready !== 1'b1);
    // one wait state is promised, so the answer edge is the second one
    check(32'(n), 32'h0000_0002);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, addr, wd, rd, err);
  endtask

  task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, addr, 32'h0000_0000, rd, err);
    check(rd, exp);
  endtask

  // live stack bits plus the read-only overflow stickies
  function automatic logic [31:0] liveBits();
    logic [31:0] v;
    v = 32'h0000_0000;
    v[`SSF_BIT_LOOP_EMPTY] = loopEmpty;
    v[`SSF_BIT_LOOP_OVF] = expLoopOvf;
    v[`SSF_BIT_SS_EMPTY] = ssEmpty;
    v[`SSF_BIT_SS_OVF] = expSsOvf;
    v[`SSF_BIT_PC_EMPTY] = (pcPtr == 5'h00);
    v[`SSF_BIT_PC_FULL] = (pcPtr == 5'h1f);
    return v;
  endfunction

  // sticky bits expected from source i of the live flag struct, lsb first
  function automatic logic [31:0] stickyOf(input int i);
    case (i)
      0: return 32'h0002_0000;
      1: return 32'h0004_0000;
      2: return 32'h0008_0000;
      3: return 32'h0010_0000;
      4: return 32'h0000_00c0;
      5: return 32'h0000_0100;
      6: return 32'h0000_0200;
      7: return 32'h0000_0001;
      8: return 32'h0000_0006;
      default: return 32'h0000_0020;
    endcase
  endfunction

  // ************************************************
  // scenarios
  // ************************************************
  task automatic sweep_sources(input logic pe);
    logic [11:0] own;
    logic [11:0] other;
    own = pe ? `SSF_OFF_Y_STICKY : `SSF_OFF_X_STICKY;
    other = pe ? `SSF_OFF_X_STICKY : `SSF_OFF_Y_STICKY;
    for (int i = 0; i < 10; i++) begin
      @(posedge sysClk);
      if (pe) begin
        yFlags <= ssf_pkg::ssf_arith_t'(10'h001 << i);
      end else begin
        xFlags <= ssf_pkg::ssf_arith_t'(10'h001 << i);
      end
      // one-cycle pulse: the bit must outlast its source
      @(posedge sysClk);
      xFlags <= '0;
      yFlags <= '0;
      rdchk(own, liveBits() | stickyOf(i));
      rdchk(other, liveBits());
      wr(own, 32'h0000_0000);
      rdchk(own, liveBits());
    end
  endtask

  task automatic detect_gate();
    wr(`SSF_OFF_MODE, 32'h0000_0000);
    check(detectEn, 1'b0);
    @(posedge sysClk);
    xFlags <= ssf_pkg::ssf_arith_t'(10'h004);
    @(posedge sysClk);
    xFlags <= '0;
    rdchk(`SSF_OFF_X_STICKY, liveBits());
    wr(`SSF_OFF_MODE, 32'h0000_0001);
    rdchk(`SSF_OFF_MODE, 32'h0000_0001);
    check(detectEn, 1'b1);
  endtask

  task automatic write_mask();
    wr(`SSF_OFF_X_STICKY, 32'hffff_ffff);
    rdchk(`SSF_OFF_X_STICKY, liveBits() | 32'h001e_03e7);
    wr(`SSF_OFF_X_STICKY, 32'h0000_0000);
    rdchk(`SSF_OFF_X_STICKY, liveBits());
  endtask

  task automatic stack_bits();
    @(posedge sysClk);
    loopEmpty <= 1'b0;
    ssEmpty <= 1'b0;
    pcPtr <= 5'h1f;
    rdchk(`SSF_OFF_X_STICKY, 32'h0020_0000);
    rdchk(`SSF_OFF_Y_STICKY, 32'h0020_0000);
    @(posedge sysClk);
    pcPtr <= 5'h05;
    rdchk(`SSF_OFF_X_STICKY, 32'h0000_0000);
    @(posedge sysClk);
    loopOvf <= 1'b1;
    ssOvf <= 1'b1;
    pcPtr <= 5'h00;
    @(posedge sysClk);
    loopOvf <= 1'b0;
    ssOvf <= 1'b0;
    loopEmpty <= 1'b1;
    ssEmpty <= 1'b1;
    expLoopOvf = 1'b1;
    expSsOvf = 1'b1;
    // overflow stickies ignore writes of zero
    wr(`SSF_OFF_Y_STICKY, 32'h0000_0000);
    rdchk(`SSF_OFF_X_STICKY, 32'h07c0_0000);
    rdchk(`SSF_OFF_Y_STICKY, 32'h07c0_0000);
  endtask

  task automatic data_regs();
    for (int n = 0; n < 16; n += 15) begin
      wr(12'h104 + 12'(8 * n), 32'hffff_ff5a + 32'(n));
      wr(12'h100 + 12'(8 * n), 32'hdead_beef ^ 32'(n));
    end
    for (int n = 0; n < 16; n += 15) begin
      rdchk(12'h100 + 12'(8 * n), 32'hdead_beef ^ 32'(n));
      rdchk(12'h104 + 12'(8 * n), 32'h0000_005a + 32'(n));
    end
  endtask

  task automatic unmapped();
    logic [31:0] rd;
    logic err;
    wr(12'h00c, 32'hffff_ffff);
    apb(1'b0, 12'h00c, 32'h0000_0000, rd, err);
    check(err, 1'b1);
    check(rd, 32'h0000_0000);
    apb(1'b0, 12'h180, 32'h0000_0000, rd, err);
    check(err, 1'b1);
    rdchk(`SSF_OFF_X_STICKY, liveBits());
  endtask

  // a second reset clears overflow stickies and data words
  task automatic mid_reset();
    @(posedge sysClk);
    resetN <= 1'b0;
    repeat (2) @(posedge sysClk);
    resetN <= 1'b1;
    expLoopOvf = 1'b0;
    expSsOvf = 1'b0;
    rdchk(`SSF_OFF_X_STICKY, 32'h0540_0000);
    rdchk(`SSF_OFF_MODE, 32'h0000_0000);
    rdchk(12'h178, 32'h0000_0000);
  endtask

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    repeat (2) @(posedge sysClk);
    resetN <= 1'b1;
    rdchk(`SSF_OFF_X_STICKY, 32'h0540_0000);
    rdchk(`SSF_OFF_Y_STICKY, 32'h0540_0000);
    detect_gate();
    sweep_sources(1'b0);
    sweep_sources(1'b1);
    write_mask();
    stack_bits();
    data_regs();
    unmapped();
    mid_reset();
    end_of_test();
  end
endmodule

`default_nettype wire
